// ---- verilog/pirqe_pkg.sv ----
// Package for the peripheral interrupt enable registers.
// Assumes a 32-bit APB slave with word-aligned registers.
package pirqe_pkg;
   localparam logic [11:0] PIRQE_OFS_CAPTURE = 12'h000;
   localparam logic [11:0] PIRQE_OFS_PWM_RTC = 12'h004;
   localparam logic [11:0] PIRQE_OFS_MISC    = 12'h008;
   localparam int          PIRQE_REG_W       = 16;
   localparam int          PIRQE_BIT_CAP3    = 5;
   localparam int          PIRQE_BIT_FLTA    = 15;
   localparam int          PIRQE_BIT_RTC     = 14;
   localparam int          PIRQE_BIT_PWM     = 9;
   localparam int          PIRQE_BIT_CTMU    = 13;
   localparam int          PIRQE_BIT_UERR    = 1;
   localparam int          PIRQE_BIT_FLTB    = 0;
   localparam logic [15:0] PIRQE_MASK_CAPTURE = 16'h0020;
   localparam logic [15:0] PIRQE_MASK_PWM_RTC = 16'hc200;
   localparam logic [15:0] PIRQE_MASK_MISC    = 16'h2003;
   localparam logic [15:0] PIRQE_MASK_MC_3    = 16'h8200;
   localparam logic [15:0] PIRQE_MASK_MC_4    = 16'h0001;
   localparam logic [15:0] PIRQE_RST_VAL      = 16'h0000;
endpackage

// ---- verilog/pirqe_enreg.sv ----
// One enable register with a fixed mask of implemented bits.
// Assumes write strobe and data are in the mclk_in domain.
`timescale 1ns/1ps
module pirqe_enreg
   import pirqe_pkg::*;
#(
   parameter logic [15:0] IMPL_MASK = 16'h0000
) (
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   input  wire logic        wr_in,
   input  wire logic [15:0] wdata_in,
   output logic      [15:0] q_out
);
   logic [15:0] en_ff;

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         en_ff <= PIRQE_RST_VAL;
      end else if (wr_in) begin
         en_ff <= wdata_in & IMPL_MASK;
      end
   end

   assign q_out = en_ff;
endmodule

// ---- verilog/pirqe_top.sv ----
// Peripheral interrupt enable registers behind an APB slave.
// Assumes APB master on mclk_in; source requests are synchronous to mclk_in.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module pirqe_top
   import pirqe_pkg::*;
#(
   parameter bit MOTOR_CTRL = 1'b1
) (
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        capture3_req_in,
   input  wire logic        pwm_fault_a_req_in,
   input  wire logic        calendar_req_in,
   input  wire logic        pwm_gen_req_in,
   input  wire logic        charge_timer_req_in,
   input  wire logic        uart_error_req_in,
   input  wire logic        pwm_fault_b_req_in,
   output logic      [6:0]  irq_req_out
);
   localparam logic [15:0] MASK3 = MOTOR_CTRL ? PIRQE_MASK_PWM_RTC
                                              : (PIRQE_MASK_PWM_RTC & ~PIRQE_MASK_MC_3);
   localparam logic [15:0] MASK4 = MOTOR_CTRL ? PIRQE_MASK_MISC
                                              : (PIRQE_MASK_MISC & ~PIRQE_MASK_MC_4);

   logic        setup;
   logic        hit_cap;
   logic        hit_pwm;
   logic        hit_misc;
   logic        mapped;
   logic [15:0] cap_q;
   logic [15:0] pwm_q;
   logic [15:0] misc_q;
   logic        acc_ff;
   logic [6:0]  nxt_req;

   // Compares a bus address with one register's byte offset
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
      return addr == ofs;
   endfunction

   // Setup phase is answered one cycle later with pready
   assign setup    = psel_in && !penable_in;
   assign hit_cap  = reg_hit(paddr_in, PIRQE_OFS_CAPTURE);
   assign hit_pwm  = reg_hit(paddr_in, PIRQE_OFS_PWM_RTC);
   assign hit_misc = reg_hit(paddr_in, PIRQE_OFS_MISC);
   assign mapped   = hit_cap || hit_pwm || hit_misc;

   pirqe_enreg #(.IMPL_MASK(PIRQE_MASK_CAPTURE)) u_cap (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .wr_in    (acc_ff && pwrite_in && hit_cap),
      .wdata_in (pwdata_in[15:0]),
      .q_out    (cap_q)
   );

   pirqe_enreg #(.IMPL_MASK(MASK3)) u_pwm (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .wr_in    (acc_ff && pwrite_in && hit_pwm),
      .wdata_in (pwdata_in[15:0]),
      .q_out    (pwm_q)
   );

   pirqe_enreg #(.IMPL_MASK(MASK4)) u_misc (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .wr_in    (acc_ff && pwrite_in && hit_misc),
      .wdata_in (pwdata_in[15:0]),
      .q_out    (misc_q)
   );

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc_ff <= 1'b0;
      end else begin
         acc_ff <= setup;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= setup;
         pslverr_out <= setup && !mapped;
         prdata_out  <= 32'h0000_0000;
         if (setup && !pwrite_in) begin
            if (hit_cap) begin
               prdata_out <= {16'h0000, cap_q};
            end else if (hit_pwm) begin
               prdata_out <= {16'h0000, pwm_q};
            end else if (hit_misc) begin
               prdata_out <= {16'h0000, misc_q};
            end
         end
      end
   end

   always_comb begin
      nxt_req[0] = capture3_req_in     & cap_q[PIRQE_BIT_CAP3];
      nxt_req[1] = pwm_fault_a_req_in  & pwm_q[PIRQE_BIT_FLTA];
      nxt_req[2] = calendar_req_in     & pwm_q[PIRQE_BIT_RTC];
      nxt_req[3] = pwm_gen_req_in      & pwm_q[PIRQE_BIT_PWM];
      nxt_req[4] = charge_timer_req_in & misc_q[PIRQE_BIT_CTMU];
      nxt_req[5] = uart_error_req_in   & misc_q[PIRQE_BIT_UERR];
      nxt_req[6] = pwm_fault_b_req_in  & misc_q[PIRQE_BIT_FLTB];
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_req_out <= 7'h00;
      end else begin
         irq_req_out <= nxt_req;
      end
   end

   AST_GATE_CAP3: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !cap_q[PIRQE_BIT_CAP3] |=> !irq_req_out[0])
      else $error("capture 3 request passed while disabled");
   AST_UNIMPL_ZERO: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (cap_q & ~PIRQE_MASK_CAPTURE) == 16'h0000 && (pwm_q & ~MASK3) == 16'h0000
      && (misc_q & ~MASK4) == 16'h0000)
      else $error("unimplemented bit set");
   AST_FLTA_RW: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      acc_ff && pwrite_in && hit_pwm |=> pwm_q[PIRQE_BIT_FLTA] == (MOTOR_CTRL
         && $past(pwdata_in[PIRQE_BIT_FLTA])))
      else $error("fault A enable not written");
   AST_RTC_RW: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      acc_ff && pwrite_in && hit_pwm
      |=> pwm_q[PIRQE_BIT_RTC] == $past(pwdata_in[PIRQE_BIT_RTC]))
      else $error("calendar enable not written");
   AST_PWM_GATE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      pwm_gen_req_in && pwm_q[PIRQE_BIT_PWM] |=> irq_req_out[3])
      else $error("pwm request blocked while enabled");
   AST_RESET_CLEAR: assert property (@(posedge mclk_in)
      !rstn_in |-> cap_q == 16'h0000 && pwm_q == 16'h0000 && misc_q == 16'h0000)
      else $error("enable not cleared in reset");
   AST_VARIANT: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !MOTOR_CTRL |-> !pwm_q[PIRQE_BIT_FLTA] && !pwm_q[PIRQE_BIT_PWM] && !misc_q[0])
      else $error("motor bits present in other variant");
   AST_PASS: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      uart_error_req_in && misc_q[PIRQE_BIT_UERR] |=> irq_req_out[5])
      else $error("uart error request suppressed while enabled");
   AST_CTMU_RW: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      acc_ff && pwrite_in && hit_misc
      |=> misc_q[PIRQE_BIT_CTMU] == $past(pwdata_in[PIRQE_BIT_CTMU]))
      else $error("charge timer enable not written");

   // A transfer is a setup cycle followed by the access cycle that pready ends
   sequence seq_setup;
      psel_in && !penable_in;
   endsequence

   sequence seq_xfer;
      seq_setup ##1 (psel_in && penable_in && pready_out);
   endsequence

   AST_READY: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      seq_setup |=> pready_out)
      else $error("no ready after setup");
   AST_READY_PULSE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      pready_out |=> !pready_out)
      else $error("ready stood two cycles");
   AST_ERR_WITH_READY: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      pslverr_out |-> pready_out)
      else $error("error response without ready");
   AST_PRDATA_IDLE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !pready_out |-> prdata_out == 32'h0000_0000)
      else $error("read data not zero outside access");
   AST_UPPER_ZERO: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      seq_xfer ##0 !pwrite_in |-> prdata_out[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   AST_UNMAPPED: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      seq_xfer ##0 !mapped |-> pslverr_out && prdata_out == 32'h0000_0000)
      else $error("unmapped access not refused");
   AST_MAPPED_OK: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      seq_xfer ##0 mapped |-> !pslverr_out)
      else $error("mapped access refused");

   AST_CAP3_RW: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      seq_xfer ##0 (pwrite_in && hit_cap)
      |=> cap_q[PIRQE_BIT_CAP3] == $past(pwdata_in[PIRQE_BIT_CAP3]))
      else $error("capture 3 enable not written");
   AST_PWM_RW: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      seq_xfer ##0 (pwrite_in && hit_pwm)
      |=> pwm_q[PIRQE_BIT_PWM] == (MOTOR_CTRL && $past(pwdata_in[PIRQE_BIT_PWM])))
      else $error("pwm enable not written");
   AST_UERR_RW: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      seq_xfer ##0 (pwrite_in && hit_misc)
      |=> misc_q[PIRQE_BIT_UERR] == $past(pwdata_in[PIRQE_BIT_UERR]))
      else $error("uart error enable not written");
   AST_FLTB_RW: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      seq_xfer ##0 (pwrite_in && hit_misc)
      |=> misc_q[PIRQE_BIT_FLTB] == (MOTOR_CTRL && $past(pwdata_in[PIRQE_BIT_FLTB])))
      else $error("fault B enable not written");

   AST_GATE_FLTA: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      pwm_fault_a_req_in && pwm_q[PIRQE_BIT_FLTA] |=> irq_req_out[1])
      else $error("fault A request blocked while enabled");
   AST_GATE_RTC_OFF: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !pwm_q[PIRQE_BIT_RTC] |=> !irq_req_out[2])
      else $error("calendar request passed while disabled");
   AST_GATE_PWM_OFF: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !pwm_q[PIRQE_BIT_PWM] |=> !irq_req_out[3])
      else $error("pwm request passed while disabled");
   AST_GATE_CTMU: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      charge_timer_req_in && misc_q[PIRQE_BIT_CTMU] |=> irq_req_out[4])
      else $error("charge timer request blocked while enabled");
   AST_GATE_UERR_OFF: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !misc_q[PIRQE_BIT_UERR] |=> !irq_req_out[5])
      else $error("uart error request passed while disabled");
   AST_GATE_FLTB_OFF: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !misc_q[PIRQE_BIT_FLTB] |=> !irq_req_out[6])
      else $error("fault B request passed while disabled");
endmodule

// ---- sim/pirqe_top_tb_top.sv ----
// Self-checking bench for the peripheral interrupt enable registers.
// Runs the motor-control and the basic variant side by side on one APB bus.
`timescale 1ns/1ps
module pirqe_top_tb_top;
   import pirqe_pkg::*;
   logic        mclk_in = 1'b0;
   logic        rstn_in = 1'b1;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic [6:0]  src = 7'h00;
   logic [6:0]  irq_req_out;
   logic [31:0] prdata_b;
   logic        pready_b;
   logic        pslverr_b;
   logic [6:0]  irq_b;
   logic [15:0] mdl_b [3];
   logic [15:0] msk_b [3];
   logic [31:0] rd_b;
   logic        er_b;
   logic [6:0]  en;
   logic [15:0] mdl [3];
   logic [15:0] msk [3];
   logic [11:0] ofs [4];
   logic [31:0] rd;
   logic [31:0] d;
   logic        er;
   integer      seed = 29672;
   integer      fails = 0;
   integer      comparisons = 0;
   integer      i, k, a;

   pirqe_top i_pirqe_top (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .capture3_req_in(src[0]), .pwm_fault_a_req_in(src[1]), .calendar_req_in(src[2]),
      .pwm_gen_req_in(src[3]), .charge_timer_req_in(src[4]), .uart_error_req_in(src[5]),
      .pwm_fault_b_req_in(src[6]), .irq_req_out(irq_req_out));

   // Variant without the motor-control enables, on the same bus and sources
   pirqe_top #(.MOTOR_CTRL(1'b0)) i_pirqe_top_basic (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_b), .pready_out(pready_b), .pslverr_out(pslverr_b),
      .capture3_req_in(src[0]), .pwm_fault_a_req_in(src[1]), .calendar_req_in(src[2]),
      .pwm_gen_req_in(src[3]), .charge_timer_req_in(src[4]), .uart_error_req_in(src[5]),
      .pwm_fault_b_req_in(src[6]), .irq_req_out(irq_b));

   always #2 mclk_in = ~mclk_in;

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      integer n;
      n = 0;
      @(posedge mclk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= ad;
      pwdata_in <= wd;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge mclk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 32'h1, 32'h0);
      rd = prdata_out;
      er = pslverr_out;
      rd_b = prdata_b;
      er_b = pslverr_b;
      chk("pready_basic", 32'h1, {31'h0, pready_b});
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // Gathers the model's enables in the order of the request bits
   function automatic logic [6:0] en_of(input logic [15:0] r0, input logic [15:0] r1,
                                        input logic [15:0] r2);
      return {r2[PIRQE_BIT_FLTB], r2[PIRQE_BIT_UERR], r2[PIRQE_BIT_CTMU], r1[PIRQE_BIT_PWM],
              r1[PIRQE_BIT_RTC], r1[PIRQE_BIT_FLTA], r0[PIRQE_BIT_CAP3]};
   endfunction

   // Drives new source levels and compares the gated requests two edges on
   task automatic chk_irq;
      src <= 7'($random(seed));
      repeat (2) @(posedge mclk_in);
      en = en_of(mdl[0], mdl[1], mdl[2]);
      chk("irq_req", {25'h0, en & src}, {25'h0, irq_req_out});
      en = en_of(mdl_b[0], mdl_b[1], mdl_b[2]);
      chk("irq_req_basic", {25'h0, en & src}, {25'h0, irq_b});
   endtask

   // Holds reset for the given edges, then reads every register back as zero
   task automatic reset_and_check(input integer cycles);
      rstn_in <= 1'b0;
      repeat (cycles) @(posedge mclk_in);
      rstn_in <= 1'b1;
      mdl = '{16'h0, 16'h0, 16'h0};
      mdl_b = '{16'h0, 16'h0, 16'h0};
      for (i = 0; i < 3; i++) begin
         xfer(1'b0, ofs[i], 32'h0);
         chk("reset_value", 32'h0, rd);
         chk("reset_value_basic", 32'h0, rd_b);
      end
      chk_irq();
   endtask

   initial begin
      msk = '{PIRQE_MASK_CAPTURE, PIRQE_MASK_PWM_RTC, PIRQE_MASK_MISC};
      msk_b = '{PIRQE_MASK_CAPTURE, PIRQE_MASK_PWM_RTC & ~PIRQE_MASK_MC_3,
                PIRQE_MASK_MISC & ~PIRQE_MASK_MC_4};
      ofs = '{PIRQE_OFS_CAPTURE, PIRQE_OFS_PWM_RTC, PIRQE_OFS_MISC, 12'h00c};
      reset_and_check(8);
      for (k = 0; k < 80; k++) begin
         a = $unsigned($random(seed)) % 4;
         d = $random(seed);
         xfer(1'b1, ofs[a], d);
         if (a < 3) begin
            mdl[a] = d[15:0] & msk[a];
            mdl_b[a] = d[15:0] & msk_b[a];
         end
         chk("wr_err", {31'h0, a == 3}, {31'h0, er});
         chk("wr_err_basic", {31'h0, a == 3}, {31'h0, er_b});
         xfer(1'b0, ofs[a], 32'h0);
         chk("rd_err", {31'h0, a == 3}, {31'h0, er});
         chk("rd_data", (a < 3) ? {16'h0, mdl[a]} : 32'h0, rd);
         chk("rd_err_basic", {31'h0, a == 3}, {31'h0, er_b});
         chk("rd_data_basic", (a < 3) ? {16'h0, mdl_b[a]} : 32'h0, rd_b);
         chk_irq();
      end
      // Reset in mid-run must clear every enable again
      reset_and_check(3);
      final_report();
   end

   initial begin
      #20000;
      fails++;
      final_report();
   end
endmodule
